// file: hw/mivrs_pkg.sv
// Package: register map, field layout and codes for the mixer input gain bank
`default_nettype none
package mivrs_pkg;
   // Register indices (address bus carries the index)
   localparam logic [7:0]  LINE_INPUT_GAIN_IDX      = 8'h10;
   localparam logic [7:0]  DISC_INPUT_GAIN_IDX      = 8'h12;
   localparam logic [7:0]  AUXILIARY_INPUT_GAIN_IDX = 8'h16;
   localparam logic [7:0]  PLAYBACK_PATH_GAIN_IDX   = 8'h18;
   localparam logic [7:0]  CAPTURE_SOURCE_SELECT_IDX = 8'h1a;
   // Reset values
   localparam logic [15:0] GAIN_RESET     = 16'h8808;
   localparam logic [15:0] SELECT_RESET   = 16'h0000;
   localparam logic [15:0] UNMAPPED_READ  = 16'h0000;
   // Volume field layout
   localparam int          MUTE_BIT       = 15;
   localparam int          RMUTE_BIT      = 7;
   localparam int          LEFT_LSB       = 8;
   localparam int          RIGHT_LSB      = 0;
   localparam int          GAIN_W         = 5;
   // Select field layout
   localparam int          LSEL_LSB       = 8;
   localparam int          RSEL_LSB       = 0;
   localparam int          SEL_W          = 3;
   // Attenuator codes of note
   localparam logic [4:0]  GAIN_PLUS_12DB = 5'h00;
   localparam logic [4:0]  GAIN_0DB       = 5'h08;
   localparam logic [4:0]  GAIN_MIN       = 5'h1f;
   // Record sources
   typedef enum logic [2:0] {
      MIVRS_SRC_MIC    = 3'h0,
      MIVRS_SRC_DISC   = 3'h1,
      MIVRS_SRC_MUTED  = 3'h2,
      MIVRS_SRC_AUX    = 3'h3,
      MIVRS_SRC_LINE   = 3'h4,
      MIVRS_SRC_STEREO = 3'h5,
      MIVRS_SRC_MONO   = 3'h6,
      MIVRS_SRC_PHONE  = 3'h7
   } mivrs_src_t;
endpackage
`default_nettype wire

// file: hw/mivrs_bank.sv
// Mixer input gain and record select register bank
//
// The plain strobed port was chosen for this implementation.
`default_nettype none
// Notes on behaviour
// R1: Each stereo gain register holds a 5-bit left and a 5-bit right code in 1.5 dB steps, +12 dB to -34.5 dB.
// R2: Code 0x00 is +12 dB, 0x08 is 0 dB, 0x1F is -34.5 dB, and codes read back as written.
// R3: The four gain registers reset to 0x8808, 0 dB both sides, bit 15 set and bit 7 clear: both muted with split mute off, only left with it on.
// R4: With split mute off, bit 15 mutes both channels.
// R5: With split mute on, bit 15 mutes only the left channel.
// R6: With split mute on, bit 7 mutes the right channel on its own.
// R7: With split mute off, bit 7 reads 0 and writing it has no effect.
// R8: Line input gain sits at index 0x10, left code in bits 12:8, right in 4:0.
// R9: Disc input gain at 0x12 behaves like line input.
// R10: Auxiliary input gain at 0x16 behaves like line input.
// R11: Playback path gain at 0x18 behaves like line input and acts on the DAC path.
// R12: Capture source select at 0x1A holds left selector in bits 10:8 and right in 2:0.
// R13: Capture source select resets to 0x0000, microphone on both sides.
// R14: Selector codes decode to mic, disc, muted, aux, line, stereo mix and mono mix.
// R15: Unassigned bits are reserved with no function.
// R16: Code 7 selects the phone input; reserved bits read zero and ignore writes.
// R17: Muting keeps the stored gain code so unmuting restores it.
module mivrs_bank #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   // Register port
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [15:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [15:0]       o_rdata,
   // Option from the miscellaneous control register
   input  wire logic              i_split_mute_enable,
   // Gain codes to the mixer, index 0 line, 1 disc, 2 aux, 3 playback
   output logic      [4:0]        o_left_gain [4],
   output logic      [4:0]        o_right_gain [4],
   output logic                   o_left_mute [4],
   output logic                   o_right_mute [4],
   // Capture source per channel
   output logic      [2:0]        o_left_capture_source,
   output logic      [2:0]        o_right_capture_source,
   output logic                   o_left_capture_muted,
   output logic                   o_right_capture_muted
);
   localparam int NGAIN = 4;
   localparam logic [ADDR_W-1:0] GAIN_IDX [NGAIN] = '{
      ADDR_W'(mivrs_pkg::LINE_INPUT_GAIN_IDX),  // R8
      ADDR_W'(mivrs_pkg::DISC_INPUT_GAIN_IDX),  // R9
      ADDR_W'(mivrs_pkg::AUXILIARY_INPUT_GAIN_IDX),  // R10
      ADDR_W'(mivrs_pkg::PLAYBACK_PATH_GAIN_IDX)  // R11
   };
   localparam logic [ADDR_W-1:0] SEL_IDX = ADDR_W'(mivrs_pkg::CAPTURE_SOURCE_SELECT_IDX);

   // Stored fields; reserved bits are simply not kept
   logic       gain_mute  [NGAIN];
   logic       gain_rmute [NGAIN];
   logic [4:0] gain_left  [NGAIN];
   logic [4:0] gain_right [NGAIN];
   logic [2:0] left_capture_source;
   logic [2:0] right_capture_source;
   logic [15:0] next_rdata;

   // Gain registers
   always_ff @(posedge i_clk) begin
      for (int i = 0; i < NGAIN; i++) begin
         if (i_sys_rst) begin
            gain_mute[i]  <= mivrs_pkg::GAIN_RESET[mivrs_pkg::MUTE_BIT];  // R3
            gain_rmute[i] <= mivrs_pkg::GAIN_RESET[mivrs_pkg::RMUTE_BIT];
            gain_left[i]  <= mivrs_pkg::GAIN_RESET[mivrs_pkg::LEFT_LSB +: mivrs_pkg::GAIN_W];
            gain_right[i] <= mivrs_pkg::GAIN_RESET[mivrs_pkg::RIGHT_LSB +: mivrs_pkg::GAIN_W];
         end else if (i_wr && i_addr == GAIN_IDX[i]) begin
            gain_mute[i]  <= i_wdata[mivrs_pkg::MUTE_BIT];
            // Right mute only latches while split mute is on
            gain_rmute[i] <= i_split_mute_enable & i_wdata[mivrs_pkg::RMUTE_BIT];  // R7
            gain_left[i]  <= i_wdata[mivrs_pkg::LEFT_LSB +: mivrs_pkg::GAIN_W];  // R1 R2
            gain_right[i] <= i_wdata[mivrs_pkg::RIGHT_LSB +: mivrs_pkg::GAIN_W];  // R1 R2
         end
      end
   end

   // Capture selector register
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         left_capture_source  <= mivrs_pkg::SELECT_RESET[mivrs_pkg::LSEL_LSB +: mivrs_pkg::SEL_W];  // R13
         right_capture_source <= mivrs_pkg::SELECT_RESET[mivrs_pkg::RSEL_LSB +: mivrs_pkg::SEL_W];  // R13
      end else if (i_wr && i_addr == SEL_IDX) begin
         left_capture_source  <= i_wdata[mivrs_pkg::LSEL_LSB +: mivrs_pkg::SEL_W];  // R12
         right_capture_source <= i_wdata[mivrs_pkg::RSEL_LSB +: mivrs_pkg::SEL_W];  // R12
      end
   end

   // Read mux; reserved bits return zero
   always_comb begin
      next_rdata = mivrs_pkg::UNMAPPED_READ;  // R15 R16
      for (int i = 0; i < NGAIN; i++) begin
         if (i_addr == GAIN_IDX[i]) begin
            next_rdata[mivrs_pkg::MUTE_BIT] = gain_mute[i];
            next_rdata[mivrs_pkg::RMUTE_BIT] = gain_rmute[i] & i_split_mute_enable;  // R7
            next_rdata[mivrs_pkg::LEFT_LSB +: mivrs_pkg::GAIN_W] = gain_left[i];  // R2
            next_rdata[mivrs_pkg::RIGHT_LSB +: mivrs_pkg::GAIN_W] = gain_right[i];  // R2
         end
      end
      if (i_addr == SEL_IDX) begin
         next_rdata[mivrs_pkg::LSEL_LSB +: mivrs_pkg::SEL_W] = left_capture_source;
         next_rdata[mivrs_pkg::RSEL_LSB +: mivrs_pkg::SEL_W] = right_capture_source;
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rdata <= mivrs_pkg::UNMAPPED_READ;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end else begin
         o_rdata <= mivrs_pkg::UNMAPPED_READ;
      end
   end

   // Mute decode; codes stay stored so unmute restores gain
   always_comb begin
      for (int i = 0; i < NGAIN; i++) begin
         o_left_gain[i]  = gain_left[i];  // R17
         o_right_gain[i] = gain_right[i];  // R17
         o_left_mute[i]  = gain_mute[i];  // R4 R5
         o_right_mute[i] = i_split_mute_enable ? gain_rmute[i] : gain_mute[i];  // R4 R5 R6
      end
   end

   // Capture source outputs; code 7 passes through as phone
   assign o_left_capture_source  = left_capture_source;  // R14 R16
   assign o_right_capture_source = right_capture_source;  // R14 R16
   assign o_left_capture_muted   = left_capture_source == 3'(mivrs_pkg::MIVRS_SRC_MUTED);  // R14
   assign o_right_capture_muted  = right_capture_source == 3'(mivrs_pkg::MIVRS_SRC_MUTED);  // R14
endmodule
`default_nettype wire

// file: tb/mivrs_bank_assertions.sv
// Checker for the mixer gain bank
`default_nettype none
module mivrs_bank_assertions (
   input wire logic        i_clk, i_sys_rst, i_wr, i_rd, i_split_mute_enable,
   input wire logic [7:0]  i_addr,
   input wire logic [15:0] i_wdata, o_rdata,
   input wire logic [4:0]  o_left_gain [4], o_right_gain [4],
   input wire logic        o_left_mute [4], o_right_mute [4], o_left_capture_muted, o_right_capture_muted,
   input wire logic [2:0]  o_left_capture_source, o_right_capture_source
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("rdata not idle");
   chk_line_write: assert property (i_wr && i_addr == 8'h10 |=> o_left_gain[0] == $past(i_wdata[12:8])
      && o_right_gain[0] == $past(i_wdata[4:0])) else $error("line gain");
   chk_disc_mute: assert property (i_wr && i_addr == 8'h12 |=> o_left_mute[1] == $past(i_wdata[15]))
      else $error("disc mute");
   chk_joint_mute: assert property (!i_split_mute_enable |-> o_right_mute[3] == o_left_mute[3])
      else $error("joint mute");
   chk_bit7_gated: assert property (i_wr && i_addr == 8'h16 && !i_split_mute_enable ##1 i_split_mute_enable
      |-> !o_right_mute[2]) else $error("bit7 kept");
   chk_split_mute: assert property (i_wr && i_addr == 8'h10 && i_split_mute_enable ##1 i_split_mute_enable
      |-> o_right_mute[0] == $past(i_wdata[7]) && o_left_mute[0] == $past(i_wdata[15])) else $error("split mute");
   chk_select_write: assert property (i_wr && i_addr == 8'h1a |=> {o_left_capture_source, o_right_capture_source}
      == $past({i_wdata[10:8], i_wdata[2:0]})) else $error("select");
   chk_capture_muted: assert property (o_left_capture_muted == (o_left_capture_source == 3'h2)
      && o_right_capture_muted == (o_right_capture_source == 3'h2)) else $error("capture mute");
   chk_line_read: assert property (i_rd && i_addr == 8'h10 ##1 $stable(i_split_mute_enable) |-> o_rdata ==
      {o_left_mute[0], 2'b00, o_left_gain[0], i_split_mute_enable & o_right_mute[0], 2'b00, o_right_gain[0]})
      else $error("line read");
endmodule
bind mivrs_bank mivrs_bank_assertions u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr(i_wr), .i_rd(i_rd),
   .i_split_mute_enable(i_split_mute_enable), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
   .o_left_gain(o_left_gain), .o_right_gain(o_right_gain), .o_left_mute(o_left_mute), .o_right_mute(o_right_mute),
   .o_left_capture_muted(o_left_capture_muted), .o_right_capture_muted(o_right_capture_muted),
   .o_left_capture_source(o_left_capture_source), .o_right_capture_source(o_right_capture_source));
`default_nettype wire

// file: tb/mivrs_bank_tb.sv
// Self-checking bench for the mixer gain bank
`default_nettype none
module mivrs_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_split_mute_enable = 0, lm [4], rm [4], lcm, rcm;
   logic [7:0]  i_addr = 8'h00;
   logic [15:0] i_wdata = 16'h0000, o_rdata;
   logic [4:0]  lg [4], rg [4];
   logic [2:0]  lcs, rcs;
   int          n_errors = 0, num_checks = 0;
   // Address, write data, expected readback
   logic [39:0] rows [8] = '{{8'h10, 16'h0a1f, 16'h0a1f}, {8'h10, 16'hffff, 16'h9f1f}, {8'h12, 16'h0000, 16'h0000},
      {8'h12, 16'h9f9f, 16'h9f1f}, {8'h16, 16'h0808, 16'h0808}, {8'h18, 16'h1f1f, 16'h1f1f},
      {8'h1a, 16'hffff, 16'h0707}, {8'h14, 16'hffff, 16'h0000}};
   always #2.5 i_clk = ~i_clk;
   mivrs_bank u_mivrs_bank (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_split_mute_enable(i_split_mute_enable), .o_left_gain(lg), .o_right_gain(rg),
      .o_left_mute(lm), .o_right_mute(rm), .o_left_capture_source(lcs), .o_right_capture_source(rcs),
      .o_left_capture_muted(lcm), .o_right_capture_muted(rcm));
   task automatic chk(input string nm, input logic [15:0] e, g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk("rdata", e, o_rdata);
   endtask
   // Split option lives outside, so reset leaves it alone
   task automatic rst_chk;
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      foreach (rows[i]) if (i < 6 && i % 2 == 0 || i == 5) rd(rows[i][39:32], 16'h8808);
      rd(8'h1a, 16'h0000);
      $display("reset test done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #20000;
      n_errors++;
      wrap_up;
   end
   initial begin
      rst_chk;
      foreach (rows[i]) begin
         wr(rows[i][39:32], rows[i][31:16]);
         rd(rows[i][39:32], rows[i][15:0]);
      end
      chk("lgain1", 16'h001f, {11'h0, lg[1]});
      chk("lmute1", 16'h0001, {15'h0, lm[1]});
      chk("rgain2", 16'h0008, {11'h0, rg[2]});
      chk("lgain3", 16'h001f, {11'h0, lg[3]});
      $display("table test done");
      i_split_mute_enable <= 1'b1;
      wr(8'h10, 16'h0a9f);
      chk("rmute", 16'h0001, {15'h0, rm[0]});
      rd(8'h10, 16'h0a9f);
      wr(8'h10, 16'h8a1f);
      chk("rmute", 16'h0000, {15'h0, rm[0]});
      chk("lmute", 16'h0001, {15'h0, lm[0]});
      i_split_mute_enable <= 1'b0;
      #1 chk("rmute", 16'h0001, {15'h0, rm[0]});
      chk("lgain", 16'h000a, {11'h0, lg[0]});
      wr(8'h16, 16'h0080);
      i_split_mute_enable <= 1'b1;
      rd(8'h16, 16'h0000);
      $display("mute test done");
      for (int k = 0; k < 8; k++) begin
         wr(8'h1a, {5'h0, 3'(k), 5'h0, 3'(7 - k)});
         chk("lsrc", 16'(k), {13'h0, lcs});
         chk("rsrc", 16'(7 - k), {13'h0, rcs});
         chk("lmuted", 16'(k == 2), {15'h0, lcm});
         chk("rmuted", 16'(k == 5), {15'h0, rcm});
      end
      $display("select test done");
      rst_chk;
      wrap_up;
   end
endmodule
`default_nettype wire
